// ---- hw/fsp_status_protect.sv ----
/*
 * Status register, write-enable latch and write protection of a serial
 * flash, with the serial front end for status read, status write, latch
 * commands and the plain read stream.
 * Assumes sclk/cs_n come from an SPI host, mem_data is a combinational
 * lookup of mem_addr in the sclk domain, and a program/erase engine on
 * clk asks pe_req and reports pe_active/pe_done.
 */
`timescale 1ns/1ns
`include "fsp_params.svh"
module fsp_status_protect #(
    parameter int ADDR_W = `FSP_ADDR_BITS,
    parameter int TW_CYCLES = `FSP_TW_NS / `FSP_CLK_NS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic serial_in_line,
    output logic serial_out,
    output logic serial_out_oe_n,
    input wire logic lock_input_pin,
    output logic [ADDR_W-1:0] mem_addr,
    input wire logic [7:0] mem_data,
    input wire fsp_pkg::fsp_pe_req_type pe_req,
    output logic pe_grant,
    input wire logic pe_active,
    input wire logic pe_done,
    output logic [7:0] status_and_protect
);
    localparam int BLK_W = ADDR_W - `FSP_BLK_SHIFT;

    function automatic logic [`FSP_ADDR_BITS-1:0] inc_wrap(
        input logic [`FSP_ADDR_BITS-1:0] a);
        logic [`FSP_ADDR_BITS-1:0] r;
        r = a + `FSP_ADDR_BITS'(1);
        r[`FSP_ADDR_BITS-1:0] = r & {`FSP_ADDR_BITS{1'b1}} >>
            (`FSP_ADDR_BITS - ADDR_W);
        return r;
    endfunction

    // region of 2^(size-1) 64K blocks at top or bottom, size 7 is all
    function automatic logic prot_hit(input logic [`FSP_ADDR_BITS-1:0] a,
        input logic [2:0] bp, input logic tb);
        logic [BLK_W:0] nblk;
        logic [BLK_W:0] blk;
        logic [BLK_W:0] total;
        nblk = (BLK_W+1)'(1) << (bp - 3'h1);
        blk = {1'b0, a[ADDR_W-1:`FSP_BLK_SHIFT]};
        total = (BLK_W+1)'(1) << BLK_W;
        if (bp == 3'h0)
            return 1'b0;
        if (bp == 3'h7)
            return 1'b1;
        return tb ? (blk < nblk) : (blk >= total - nblk);
    endfunction

    // link domain, rising edge: capture of opcode, data and address
    logic [5:0] cnt;
    logic [6:0] shin;
    logic [`FSP_ADDR_BITS-1:0] addr;
    logic [2:0] dbit;
    logic stat_mode;
    logic rd_cmd;
    logic rd_mode;
    logic frame_tog;
    fsp_pkg::fsp_frame_type frame;
    logic [7:0] stat_l1;
    logic [7:0] stat_l2;
    logic [7:0] stat_l3;
    logic [7:0] stat_ok;
    logic [6:0] out_sr;

    wire [7:0] in_byte = {shin, serial_in_line};
    wire [5:0] next_cnt = (cnt == `FSP_CNT_MAX) ? cnt : cnt + 6'h01;
    wire is_opc = (cnt == `FSP_CNT_OPC);
    wire link_busy = stat_ok[`FSP_BIT_WIP];
    wire out_phase = stat_mode | rd_mode;
    wire fsp_pkg::fsp_len_type next_len =
        (next_cnt == `FSP_LEN_ONE_BITS) ? fsp_pkg::FSP_LEN_ONE :
        (next_cnt == `FSP_LEN_TWO_BITS) ? fsp_pkg::FSP_LEN_TWO :
        fsp_pkg::FSP_LEN_OTHER;

    // per-frame state, cleared by the frame's own select
    always_ff @(posedge sclk or posedge cs_n or negedge rst_n)
    begin
        if (!rst_n || cs_n)
        begin
            cnt <= 6'h00;
            shin <= 7'h00;
            dbit <= 3'h0;
            stat_mode <= 1'b0;
            rd_cmd <= 1'b0;
            rd_mode <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            shin <= in_byte[6:0];
            if (out_phase)
                dbit <= dbit + 3'h1;
            if (is_opc && in_byte == `FSP_OP_STAT_RD)
                stat_mode <= 1'b1;
            if (is_opc && in_byte == `FSP_OP_READ)
                rd_cmd <= !link_busy;
            if (cnt == `FSP_CNT_ADR)
                rd_mode <= rd_cmd;
        end
    end

    // frame record survives select so the clk side can judge it
    always_ff @(posedge sclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            frame <= '0;
            frame_tog <= 1'b0;
            addr <= '0;
            stat_l1 <= 8'h00;
            stat_l2 <= 8'h00;
            stat_l3 <= 8'h00;
            stat_ok <= 8'h00;
        end
        else
        begin
            stat_l1 <= status_and_protect;
            stat_l2 <= stat_l1;
            stat_l3 <= stat_l2;
            // take the byte only when two samples agree, never a torn one
            if (stat_l2 == stat_l3)
                stat_ok <= stat_l3;
            if (cnt == 6'h00)
                frame_tog <= !frame_tog;
            if (is_opc)
                frame.code <= in_byte;
            if (cnt == `FSP_CNT_DAT)
                frame.data <= in_byte;
            frame.len <= next_len;
            if (cnt > `FSP_CNT_OPC && cnt <= `FSP_CNT_ADR)
                addr <= {addr[`FSP_ADDR_BITS-2:0], serial_in_line};
            else if (rd_mode && dbit == 3'h7)
                addr <= inc_wrap(addr);
        end
    end

    assign mem_addr = addr[ADDR_W-1:0];
    wire [7:0] out_byte = stat_mode ? stat_ok : mem_data;

    // link domain, falling edge: data out, one byte per eight clocks
    always_ff @(negedge sclk or posedge cs_n or negedge rst_n)
    begin
        if (!rst_n || cs_n)
        begin
            serial_out <= 1'b0;
            serial_out_oe_n <= 1'b1;
            out_sr <= 7'h00;
        end
        else if (out_phase)
        begin
            serial_out_oe_n <= 1'b0;
            if (dbit == 3'h0)
            begin
                serial_out <= out_byte[7];
                out_sr <= out_byte[6:0];
            end
            else
            begin
                serial_out <= out_sr[6];
                out_sr <= {out_sr[5:0], 1'b0};
            end
        end
    end

    // clk domain: synchronisers
    logic cs_s1;
    logic cs_s2;
    logic cs_q;
    logic tog_s1;
    logic tog_s2;
    logic tog_q;
    logic lock_s1;
    logic lock_s2;
    logic seen;
    logic [7:0] code_c;
    logic [7:0] data_c;
    fsp_pkg::fsp_len_type len_c;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_q <= 1'b1;
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_q <= 1'b0;
            lock_s1 <= 1'b1;
            lock_s2 <= 1'b1;
        end
        else
        begin
            cs_s1 <= cs_n;
            cs_s2 <= cs_s1;
            cs_q <= cs_s2;
            tog_s1 <= frame_tog;
            tog_s2 <= tog_s1;
            tog_q <= tog_s2;
            lock_s1 <= lock_input_pin;
            lock_s2 <= lock_s1;
        end
    end

    // frame record is still once select is high; read it after sync
    assign code_c = frame.code;
    assign data_c = frame.data;
    assign len_c = frame.len;

    wire frame_end = cs_s2 && !cs_q && seen;
    wire got_start = tog_s2 != tog_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            seen <= 1'b0;
        else if (got_start)
            seen <= 1'b1;
        else if (frame_end)
            seen <= 1'b0;
    end

    // status and protection state
    logic write_enable_latch;
    logic status_lock_bit;
    logic tb;
    logic [2:0] bp;
    logic [31:0] tw_cnt;
    fsp_pkg::fsp_sw_state_type sw_state;
    logic [7:0] sw_data;

    wire sw_busy = (sw_state == fsp_pkg::FSP_SWCYC);
    wire write_in_progress = sw_busy | pe_active;
    wire hard_lock_mode = status_lock_bit && !lock_s2;
    wire soft_lock_mode = !hard_lock_mode;
    wire len_one = (len_c == fsp_pkg::FSP_LEN_ONE);
    wire len_two = (len_c == fsp_pkg::FSP_LEN_TWO);
    wire is_latch_set = frame_end && len_one &&
        code_c == `FSP_OP_LATCH_SET && !write_in_progress;
    wire is_latch_clr = frame_end && len_one &&
        code_c == `FSP_OP_LATCH_CLR && !write_in_progress;
    // the lock bit only matters while the pin is low
    wire sw_go = frame_end && len_two && code_c == `FSP_OP_STAT_WR &&
        write_enable_latch && soft_lock_mode && !write_in_progress;
    wire tw_last = (tw_cnt == 32'(TW_CYCLES - 1));

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sw_state <= fsp_pkg::FSP_IDLE;
            tw_cnt <= 32'h00000000;
            sw_data <= 8'h00;
        end
        else
        begin
            case (sw_state)
                fsp_pkg::FSP_IDLE:
                begin
                    tw_cnt <= 32'h00000000;
                    if (sw_go)
                    begin
                        sw_state <= fsp_pkg::FSP_SWCYC;
                        sw_data <= data_c;
                    end
                end
                fsp_pkg::FSP_SWCYC:
                begin
                    tw_cnt <= tw_cnt + 32'h00000001;
                    if (tw_last)
                        sw_state <= fsp_pkg::FSP_IDLE;
                end
                default:
                    sw_state <= fsp_pkg::FSP_IDLE;
            endcase
        end
    end

    wire sw_end = sw_busy && tw_last;

    // non-volatile bits load when the cycle ends; b6 b1 b0 untouched
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            {status_lock_bit, tb, bp} <= `FSP_NV_RESET;
        else if (sw_end && !hard_lock_mode)
        begin
            status_lock_bit <= sw_data[`FSP_BIT_LOCK];
            tb <= sw_data[`FSP_BIT_TB];
            bp <= sw_data[`FSP_BIT_BP_HI:`FSP_BIT_BP_LO];
        end
    end

    // latch set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            write_enable_latch <= 1'b0;
        else if (is_latch_set)
            write_enable_latch <= 1'b1;
        else if (sw_end || pe_done || is_latch_clr)
            write_enable_latch <= 1'b0;
    end

    // b6 and b5 always read as zero
    wire [7:0] next_status = {status_lock_bit, 2'b00, bp, write_enable_latch, write_in_progress};

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            status_and_protect <= 8'h00;
        else
            status_and_protect <= next_status;
    end

    // program and erase admission
    wire pe_hit = prot_hit(pe_req.addr, bp, tb);
    wire pe_chip = (pe_req.kind == fsp_pkg::FSP_PE_CHIP);
    wire pe_ok = pe_chip ? (bp == 3'h0) : !pe_hit;
    assign pe_grant = pe_req.valid && write_enable_latch && !write_in_progress && pe_ok;

    // checks
    wip_busy_a: assert property (@(posedge clk) disable iff (!rst_n)
        sw_busy |=> status_and_protect[`FSP_BIT_WIP])
        else $error("write_in_progress low during status write cycle");
    wel_needed_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(sw_busy) |-> $past(write_enable_latch))
        else $error("status write accepted without latch");
    lock_refuse_a: assert property (@(posedge clk) disable iff (!rst_n)
        (status_lock_bit && !lock_s2 && sw_state == fsp_pkg::FSP_IDLE) |=> !sw_busy)
        else $error("status write accepted in hard lock");
    chip_erase_a: assert property (@(posedge clk) disable iff (!rst_n)
        (pe_req.valid && pe_chip && bp != 3'h0) |-> !pe_grant)
        else $error("chip erase granted with protection set");
    cycle_end_a: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(sw_busy) |-> !write_enable_latch && $past(tw_cnt) == 32'(TW_CYCLES - 1))
        else $error("status write cycle end wrong");
    zero_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
        status_and_protect[6:5] == 2'b00 ##1 status_and_protect[6:5] == 2'b00)
        else $error("b6 or b5 read as one");
    lock_release_a: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(hard_lock_mode) |-> $rose(lock_s2))
        else $error("hard lock left without lock pin high");
    soft_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (sw_go && !status_lock_bit) |=> sw_busy ##1 sw_busy)
        else $error("status write refused with lock bit clear");
    addr_step_a: assert property (@(posedge sclk) disable iff (!rst_n || cs_n)
        (rd_mode && dbit == 3'h7) |=> addr == inc_wrap($past(addr)))
        else $error("read address did not step");
    stream_a: assert property (@(negedge sclk) disable iff (!rst_n || cs_n)
        (stat_mode && dbit == 3'h0) |=> serial_out == $past(stat_ok[7]))
        else $error("status byte not shifted out");
    nv_frozen_a: assert property (@(posedge clk) disable iff (!rst_n)
        hard_lock_mode |=> $stable({status_lock_bit, tb, bp}))
        else $error("protection bits changed in hard lock");
    whole_bytes_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(sw_busy) |-> $past(len_two))
        else $error("status write started from a partial frame");
    region_guard_a: assert property (@(posedge clk) disable iff (!rst_n)
        (pe_req.valid && !pe_chip && pe_hit) |-> !pe_grant)
        else $error("write granted inside protected region");
    latch_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        is_latch_set |=> write_enable_latch)
        else $error("latch not set by latch command");
endmodule

// ---- hw/fsp_params.svh ----
/*
 * Constants of the serial flash status and write-protect block.
 * Assumes one include per compile unit; plain `define values only.
 */
`ifndef FSP_PARAMS_SVH
`define FSP_PARAMS_SVH
`define FSP_OP_LATCH_SET 8'h06
`define FSP_OP_LATCH_CLR 8'h04
`define FSP_OP_STAT_RD 8'h05
`define FSP_OP_STAT_WR 8'h01
`define FSP_OP_READ 8'h03
`define FSP_BIT_WIP 0
`define FSP_BIT_WEL 1
`define FSP_BIT_BP_LO 2
`define FSP_BIT_BP_HI 4
`define FSP_BIT_TB 5
`define FSP_BIT_LOCK 7
`define FSP_ADDR_BITS 24
`define FSP_BLK_SHIFT 16
`define FSP_CNT_OPC 6'h07
`define FSP_CNT_DAT 6'h0F
`define FSP_CNT_ADR 6'h1F
`define FSP_CNT_MAX 6'h3F
`define FSP_LEN_ONE_BITS 6'h08
`define FSP_LEN_TWO_BITS 6'h10
`define FSP_TW_NS 10000000
`define FSP_CLK_NS 4
`define FSP_NV_RESET 5'h00
`endif

// ---- hw/fsp_pkg.sv ----
/*
 * Types shared by the status and write-protect block.
 * Assumes fsp_params.svh is compiled alongside.
 */
package fsp_pkg;
    typedef enum logic [1:0] {FSP_LEN_OTHER, FSP_LEN_ONE, FSP_LEN_TWO}
        fsp_len_type;
    typedef struct packed {
        logic [7:0] code;
        logic [7:0] data;
        fsp_len_type len;
    } fsp_frame_type;
    typedef enum logic [1:0] {FSP_PE_PAGE, FSP_PE_FOURK, FSP_PE_BIG,
        FSP_PE_CHIP} fsp_pe_kind_type;
    typedef struct packed {
        logic valid;
        fsp_pe_kind_type kind;
        logic [23:0] addr;
    } fsp_pe_req_type;
    typedef enum logic {FSP_IDLE, FSP_SWCYC} fsp_sw_state_type;
endpackage

// ---- tb/fsp_host_model.sv ----
/*
 * Host model for the serial link of the status and protect block.
 * Assumes mode 0 framing; the link clock stands still between frames.
 */
`timescale 1ns/1ns
module fsp_host_model (
    output logic sclk,
    output logic cs_n,
    output logic serial_in_line,
    input wire logic serial_out,
    input wire logic serial_out_oe_n
);
    logic [63:0] rx;
    logic driven;
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        serial_in_line = 1'b0;
        rx = '0;
        driven = 1'b0;
    end
    // msb first; data changes while the link clock is low
    task automatic xfer(input logic [63:0] tx, input int nbits);
        rx = '0;
        driven = 1'b0;
        #3 cs_n = 1'b0;
        for (int i = 0; i < nbits; i++)
        begin
            serial_in_line = tx[63-i];
            #80;
            // a released output reads as the inverse of its level
            rx = {rx[62:0], serial_out ^ serial_out_oe_n};
            driven = driven | ~serial_out_oe_n;
            sclk = 1'b1;
            #80 sclk = 1'b0;
        end
        #80 cs_n = 1'b1;
        // released line shows a fresh level, not the last bit
        serial_in_line = ~serial_in_line;
        #200;
    endtask
endmodule

// ---- tb/tb.sv ----
/*
 * Self-checking bench of the status and write-protect block.
 * Assumes the host model above and a shortened write cycle.
 */
`timescale 1ns/1ns
module tb;
    localparam int TW = 1200;
    logic clk;
    logic rst_n;
    logic sclk;
    logic cs_n;
    logic serial_in_line;
    logic serial_out;
    logic serial_out_oe_n;
    logic lock_input_pin;
    logic [23:0] mem_addr;
    logic [7:0] mem_data;
    fsp_pkg::fsp_pe_req_type pe_req;
    logic pe_grant;
    logic pe_active;
    logic pe_done;
    logic [7:0] status_and_protect;
    int n_errors;
    int check_count;
    logic [7:0] s;

    always #2 clk = ~clk;
    // array image: each byte derived from its own address
    assign mem_data = mem_addr[7:0] ^ 8'hA5;

    fsp_status_protect #(.TW_CYCLES(TW)) dut (
        .clk(clk),
        .rst_n(rst_n),
        .sclk(sclk),
        .cs_n(cs_n),
        .serial_in_line(serial_in_line),
        .serial_out(serial_out),
        .serial_out_oe_n(serial_out_oe_n),
        .lock_input_pin(lock_input_pin),
        .mem_addr(mem_addr),
        .mem_data(mem_data),
        .pe_req(pe_req),
        .pe_grant(pe_grant),
        .pe_active(pe_active),
        .pe_done(pe_done),
        .status_and_protect(status_and_protect)
    );
    fsp_host_model host (
        .sclk(sclk),
        .cs_n(cs_n),
        .serial_in_line(serial_in_line),
        .serial_out(serial_out),
        .serial_out_oe_n(serial_out_oe_n)
    );

    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] op, input logic [7:0] d,
        input int nb);
        host.xfer({op, d, 48'h0}, nb);
    endtask
    task automatic wr(input logic [7:0] d);
        cmd(8'h06, 8'h00, 8);
        cmd(8'h01, d, 16);
    endtask
    task automatic rd_status(output logic [7:0] v);
        host.xfer({8'h05, 56'h0}, 24);
        v = host.rx[15:8];
        chk("status repeat", v, host.rx[7:0]);
    endtask
    task automatic wait_idle;
        int k;
        k = 0;
        while (status_and_protect[0] !== 1'b0 && k < TW + 100)
        begin
            @(negedge clk);
            k++;
        end
        chk("idle in time", 1, k < TW + 100);
    endtask
    task automatic pin(input logic v);
        @(negedge clk);
        lock_input_pin = v;
        repeat (4) @(negedge clk);
    endtask
    task automatic pe(input fsp_pkg::fsp_pe_kind_type k,
        input logic [23:0] a, input logic exp);
        @(negedge clk);
        pe_req = '{valid: 1'b1, kind: k, addr: a};
        #1 chk("grant", exp, pe_grant);
        @(negedge clk);
        pe_req.valid = 1'b0;
    endtask

    task automatic t_reset;
        chk("reset status", 8'h00, status_and_protect);
        chk("reset oe", 1'b1, serial_out_oe_n);
    endtask
    task automatic t_latch;
        cmd(8'h01, 8'h9C, 16);
        chk("no latch", 8'h00, status_and_protect);
        cmd(8'h06, 8'h00, 7);
        chk("short set", 8'h00, status_and_protect);
        cmd(8'h06, 8'h00, 8);
        chk("latch set", 8'h02, status_and_protect);
        cmd(8'h04, 8'h00, 8);
        chk("latch clear", 8'h00, status_and_protect);
    endtask
    task automatic t_swrite;
        cmd(8'h06, 8'h00, 8);
        cmd(8'h01, 8'hFF, 17);
        chk("odd write", 8'h02, status_and_protect);
        cmd(8'h01, 8'hFF, 16);
        chk("cycle start", 8'h03, status_and_protect);
        rd_status(s);
        chk("busy status", 8'h03, s);
        wait_idle();
        chk("written", 8'h9C, status_and_protect);
    endtask
    task automatic t_hard_lock;
        pin(1'b0);
        wr(8'h00);
        chk("locked", 8'h9E, status_and_protect);
        pin(1'b1);
        wr(8'h24);
        wait_idle();
        chk("unlocked", 8'h04, status_and_protect);
    endtask
    task automatic t_regions;
        cmd(8'h06, 8'h00, 8);
        pe(fsp_pkg::FSP_PE_PAGE, 24'h000100, 1'b0);
        pe(fsp_pkg::FSP_PE_FOURK, 24'hFF0000, 1'b1);
        pe(fsp_pkg::FSP_PE_CHIP, 24'h000000, 1'b0);
        pin(1'b0);
        wr(8'h84);
        wait_idle();
        chk("pin low write", 8'h84, status_and_protect);
        cmd(8'h06, 8'h00, 8);
        pe(fsp_pkg::FSP_PE_BIG, 24'hFF0000, 1'b0);
        pe(fsp_pkg::FSP_PE_PAGE, 24'h000100, 1'b1);
        wr(8'h00);
        chk("lock after bit", 8'h86, status_and_protect);
        pin(1'b1);
        wr(8'h00);
        wait_idle();
        chk("cleared", 8'h00, status_and_protect);
        cmd(8'h06, 8'h00, 8);
        pe(fsp_pkg::FSP_PE_CHIP, 24'h000000, 1'b1);
    endtask
    task automatic t_read;
        host.xfer({8'h03, 24'hFFFFFE, 32'h0}, 56);
        chk("read wrap", 24'h5B5AA5, host.rx[23:0]);
        chk("read driven", 1'b1, host.driven);
    endtask
    task automatic t_busy;
        @(negedge clk);
        pe_active = 1'b1;
        repeat (4) @(negedge clk);
        chk("engine busy", 8'h03, status_and_protect);
        host.xfer({8'h03, 24'h000010, 32'h0}, 56);
        chk("busy read", 1'b0, host.driven);
        @(negedge clk);
        pe_active = 1'b0;
        pe_done = 1'b1;
        @(negedge clk);
        pe_done = 1'b0;
        repeat (4) @(negedge clk);
        chk("engine done", 8'h00, status_and_protect);
    endtask

    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        lock_input_pin = 1'b1;
        pe_req = '0;
        pe_active = 1'b0;
        pe_done = 1'b0;
        n_errors = 0;
        check_count = 0;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_reset();
        t_latch();
        t_swrite();
        t_hard_lock();
        t_regions();
        t_read();
        t_busy();
        complete_run();
    end
    initial
    begin
        #380000;
        n_errors++;
        $display("mismatch watchdog expected end seen timeout");
        complete_run();
    end
endmodule
